// ==== verilog/dma_chan_regs.vh ====
// register map, field positions and request codes of the dma channels
// How it works
// - control bit 15 enables the channel; a disabled channel moves nothing.
// - control bit 14 set moves bytes, clear moves 16-bit words.
// - control bit 13 set reads ram writes peripheral, clear the reverse.
// - control bit 12 set interrupts at half block, clear at full block.
// - control bit 11 adds a null peripheral write per ram write; direction clear.
// - bits 5-4 pick post-increment, no increment, or peripheral indirect addressing.
// - bits 1-0 pick continuous, one-shot, continuous ping-pong, one-shot ping-pong.
// - request bit 15 written one forces exactly one transfer.
// - writing zero cannot clear force; completion or disable clears it.
// - request bits 7-0 select the source that triggers automatic transfers.
// - serial codes 0b,0c,0a,1e,1f,21 select uart and spi sources.
// - codes select external interrupt, captures, compares and timers two to five.
// - codes 0d, 22, 46 select converter done, can receive, can transmit.
// - primary start address is 24 bits, split high byte and low word.
// - secondary start address uses the same split, alternate ram buffer.
// - 16-bit peripheral address gives the peripheral side of each transfer.
// - unimplemented bits in all these registers read as zero.
// - a block is the 14-bit transfer count plus one transfers.
// - fixed priority by channel number picks among pending channels.
// - ping-pong modes swap start addresses after every completed block.
// - each channel raises an interrupt at half block or at full block, as control bit 12 picks.
`ifndef DMA_CHAN_REGS_VH
`define DMA_CHAN_REGS_VH

// word index of each register inside a channel slot
`define REG_CTL        3'h0
`define REG_REQ        3'h1
`define REG_PRIM_HI    3'h2
`define REG_PRIM_LO    3'h3
`define REG_SEC_HI     3'h4
`define REG_SEC_LO     3'h5
`define REG_PERIPH     3'h6
`define REG_XCOUNT     3'h7

// control fields
`define CTL_EN         15
`define CTL_BYTE       14
`define CTL_DIR        13
`define CTL_HALF       12
`define CTL_NULL_WRITE_MODE      11
`define CTL_AM_HI      5
`define CTL_AM_LO      4
`define CTL_MD_HI      1
`define CTL_MD_LO      0
`define CTL_MASK       16'hf833
`define REQ_FORCE      15
`define XCOUNT_W       14
`define RST_VAL        16'h0000

// addressing and operating modes
`define AM_INC         2'h0
`define AM_NOINC       2'h1
`define AM_PERIPH      2'h2
`define MD_CONT        2'h0
`define MD_ONESHOT     2'h1
`define MD_CONT_PP     2'h2
`define MD_ONESHOT_PP  2'h3

// request source codes
`define SRC_EXT_ZERO   8'h00
`define SRC_CAPT_1     8'h01
`define SRC_CAPT_2     8'h05
`define SRC_CAPT_3     8'h25
`define SRC_CAPT_4     8'h26
`define SRC_CMP_1      8'h02
`define SRC_CMP_2      8'h06
`define SRC_CMP_3      8'h19
`define SRC_CMP_4      8'h1a
`define SRC_TIMER_2    8'h07
`define SRC_TIMER_3    8'h08
`define SRC_TIMER_4    8'h1b
`define SRC_TIMER_5    8'h1c
`define SRC_SPI_1      8'h0a
`define SRC_SPI_2      8'h21
`define SRC_SER_RX_1   8'h0b
`define SRC_SER_TX_1   8'h0c
`define SRC_SER_RX_2   8'h1e
`define SRC_SER_TX_2   8'h1f
`define SRC_ANALOG     8'h0d
`define SRC_CAN_RX     8'h22
`define SRC_CAN_TX     8'h46

`endif

// ==== verilog/dma_req_pick.v ====
// picks one channel's trigger from the request lines by its source code
`timescale 1ns/1ps
`default_nettype none
`include "dma_chan_regs.vh"
module dma_req_pick #(
  parameter HAS_CAN_TX = 1
) (
  // request lines indexed by source code
  input  wire [255:0] req_i,
  // source code of the channel
  input  wire [7:0]   code_i,
  // selected trigger
  output wire         hit_o
);

  // unwired codes never fire
  function is_known;
    input [7:0] c;
    begin
      case (c)
        `SRC_SER_RX_1, `SRC_SER_TX_1, `SRC_SPI_1,
        `SRC_SER_RX_2, `SRC_SER_TX_2, `SRC_SPI_2: is_known = 1'b1;
        `SRC_EXT_ZERO, `SRC_CAPT_1, `SRC_CAPT_2, `SRC_CAPT_3,
        `SRC_CAPT_4, `SRC_CMP_1, `SRC_CMP_2, `SRC_CMP_3,
        `SRC_CMP_4, `SRC_TIMER_2, `SRC_TIMER_3, `SRC_TIMER_4,
        `SRC_TIMER_5: is_known = 1'b1;
        `SRC_ANALOG, `SRC_CAN_RX: is_known = 1'b1;
        `SRC_CAN_TX: is_known = (HAS_CAN_TX != 0);
        default: is_known = 1'b0;
      endcase
    end
  endfunction

  assign hit_o = is_known(code_i) & req_i[code_i];
endmodule
`default_nettype wire

// ==== verilog/dma_prio_arb.v ====
// fixed priority arbiter, lowest channel number wins
`timescale 1ns/1ps
`default_nettype none
module dma_prio_arb #(
  parameter NCH = 4,
  parameter CW  = 2
) (
  // pending requests
  input  wire [NCH-1:0] pend_i,
  // winner
  output reg  [CW-1:0]  gnt_o,
  output wire           any_o
);
  integer i;

  // lowest index assigns last and wins
  always @* begin
    gnt_o = {CW{1'b0}};
    for (i = NCH - 1; i >= 0; i = i - 1) begin
      if (pend_i[i]) begin
        gnt_o = i[CW-1:0];
      end
    end
  end

  assign any_o = |pend_i;
endmodule
`default_nettype wire

// ==== verilog/dma_chan_top.v ====
// four dma channels: avalon registers, request pick and transfer engine
//
// Chosen here: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "dma_chan_regs.vh"
module dma_chan_top #(
  parameter NCH        = 4,
  parameter HAS_CAN_TX = 1
) (
  // clock, reset, enable
  input  wire        mclk_i,
  input  wire        rst_n_i,
  input  wire        ce_i,
  // avalon-mm slave, byte address
  input  wire [6:0]  avs_address_i,
  input  wire [3:0]  avs_byteenable_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  output reg  [31:0] avs_readdata_o,
  output wire        avs_waitrequest_o,
  // peripheral request lines and indirect address
  input  wire [255:0] req_i,
  input  wire [15:0]  periph_offset_i,
  // data bus master toward ram and peripherals
  output reg         bus_req_o,
  output reg         bus_we_o,
  output reg         bus_ram_o,
  output reg         bus_byte_o,
  output reg  [23:0] bus_addr_o,
  output reg  [15:0] bus_wdata_o,
  input  wire [15:0] bus_rdata_i,
  input  wire        bus_ack_i,
  // block interrupts, one pulse per event
  output reg  [3:0]  blk_int_o
);

  localparam S_IDLE = 2'h0;
  localparam S_RD   = 2'h1;
  localparam S_WR   = 2'h2;
  localparam S_NUL  = 2'h3;

  // software registers
  reg [15:0] ctl_ff       [0:NCH-1];
  reg [7:0]  src_sel_ff   [0:NCH-1];
  reg        force_ff     [0:NCH-1];
  reg [7:0]  prim_hi_ff   [0:NCH-1];
  reg [15:0] prim_lo_ff   [0:NCH-1];
  reg [7:0]  sec_hi_ff    [0:NCH-1];
  reg [15:0] sec_lo_ff    [0:NCH-1];
  reg [15:0] periph_ff    [0:NCH-1];
  reg [13:0] xcount_ff    [0:NCH-1];
  // channel run state
  reg [23:0] ram_addr_ff  [0:NCH-1];
  reg [13:0] idx_ff       [0:NCH-1];
  reg        pp_ff        [0:NCH-1];
  reg [NCH-1:0] pend_ff;
  // engine state
  reg [1:0]  state_ff;
  reg [1:0]  cur_ff;
  reg        cur_forced_ff;
  reg [15:0] data_ff;
  reg        rd_done_ff;

  wire [1:0] reg_ch  = avs_address_i[6:5];
  wire [2:0] reg_idx = avs_address_i[4:2];
  wire       wr_go   = ce_i & avs_write_i;
  wire [15:0] wmask  = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

  // full 24-bit address of one of the two start buffers
  function [23:0] start_addr;
    input [7:0]  hi;
    input [15:0] lo;
    begin
      start_addr = {hi, lo};
    end
  endfunction

  // masked merge of a write into a stored word
  function [15:0] merge;
    input [15:0] old;
    input [15:0] nw;
    input [15:0] m;
    begin
      merge = (old & ~m) | (nw & m);
    end
  endfunction

  // count write merged at full width, then cut to the 14 stored bits
  wire [15:0] xcnt_mrg = merge({2'h0, xcount_ff[reg_ch]},
                               avs_writedata_i[15:0], wmask & 16'h3fff);

  // per-channel trigger lines
  wire [NCH-1:0] trig;
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : pick
      dma_req_pick #(
        .HAS_CAN_TX (HAS_CAN_TX)
      ) u_pick (
        .req_i  (req_i),
        .code_i (src_sel_ff[g]),
        .hit_o  (trig[g])
      );
    end
  endgenerate

  wire [1:0] gnt;
  wire       gnt_any;
  dma_prio_arb #(
    .NCH (NCH),
    .CW  (2)
  ) u_arb (
    .pend_i (pend_ff),
    .gnt_o  (gnt),
    .any_o  (gnt_any)
  );

  // current channel decode
  wire [15:0] cur_ctl   = ctl_ff[cur_ff];
  wire        cur_byte  = cur_ctl[`CTL_BYTE];
  wire        cur_dir   = cur_ctl[`CTL_DIR];
  wire [1:0]  cur_am    = cur_ctl[`CTL_AM_HI:`CTL_AM_LO];
  wire [1:0]  cur_md    = cur_ctl[`CTL_MD_HI:`CTL_MD_LO];
  wire [23:0] cur_base  = pp_ff[cur_ff] ?
                          start_addr(sec_hi_ff[cur_ff], sec_lo_ff[cur_ff]) :
                          start_addr(prim_hi_ff[cur_ff],
                                     prim_lo_ff[cur_ff]);
  // peripheral indirect takes the offset from the peripheral
  wire [23:0] cur_ram   = (cur_am == `AM_PERIPH) ?
                          cur_base + {8'h00, periph_offset_i} :
                          ram_addr_ff[cur_ff];
  wire [23:0] cur_per   = {8'h00, periph_ff[cur_ff]};
  wire [13:0] cur_cnt   = xcount_ff[cur_ff];
  wire        last_xfer = (idx_ff[cur_ff] == cur_cnt);
  wire [14:0] cnt_p1    = {1'b0, cur_cnt} + 15'h0001;
  wire [14:0] idx_p1    = {1'b0, idx_ff[cur_ff]} + 15'h0001;
  wire        half_hit  = (idx_p1 == {1'b0, cnt_p1[14:1]});
  wire        xfer_end  = bus_ack_i &
                          (((state_ff == S_WR) &
                            ~(cur_ctl[`CTL_NULL_WRITE_MODE] & ~cur_dir)) |
                           (state_ff == S_NUL));
  wire        pp_mode   = cur_md[1];
  wire        one_shot  = cur_md[0];
  wire [23:0] step      = cur_byte ? 24'h000001 : 24'h000002;

  // reads take one wait state so read data comes from a flop
  assign avs_waitrequest_o = avs_read_i & ~rd_done_ff;

  // register read mux; unused bits are zero
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= 32'h00000000;
      rd_done_ff     <= 1'b0;
    end else if (ce_i) begin
      rd_done_ff <= avs_read_i & ~rd_done_ff;
      if (avs_read_i & ~rd_done_ff) begin
        if (reg_idx == `REG_CTL) begin
          avs_readdata_o <= {16'h0000, ctl_ff[reg_ch] & `CTL_MASK};
        end else if (reg_idx == `REG_REQ) begin
          avs_readdata_o <= {16'h0000, force_ff[reg_ch], 7'h00,
                             src_sel_ff[reg_ch]};
        end else if (reg_idx == `REG_PRIM_HI) begin
          avs_readdata_o <= {24'h000000, prim_hi_ff[reg_ch]};
        end else if (reg_idx == `REG_PRIM_LO) begin
          avs_readdata_o <= {16'h0000, prim_lo_ff[reg_ch]};
        end else if (reg_idx == `REG_SEC_HI) begin
          avs_readdata_o <= {24'h000000, sec_hi_ff[reg_ch]};
        end else if (reg_idx == `REG_SEC_LO) begin
          avs_readdata_o <= {16'h0000, sec_lo_ff[reg_ch]};
        end else if (reg_idx == `REG_PERIPH) begin
          avs_readdata_o <= {16'h0000, periph_ff[reg_ch]};
        end else begin
          avs_readdata_o <= {18'h00000, xcount_ff[reg_ch]};
        end
      end
    end
  end

  // registers and per-channel run state; software writes come last
  integer c;
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (c = 0; c < NCH; c = c + 1) begin
        ctl_ff[c]      <= `RST_VAL;
        src_sel_ff[c]  <= 8'h00;
        force_ff[c]    <= 1'b0;
        prim_hi_ff[c]  <= 8'h00;
        prim_lo_ff[c]  <= `RST_VAL;
        sec_hi_ff[c]   <= 8'h00;
        sec_lo_ff[c]   <= `RST_VAL;
        periph_ff[c]   <= `RST_VAL;
        xcount_ff[c]   <= 14'h0000;
        ram_addr_ff[c] <= 24'h000000;
        idx_ff[c]      <= 14'h0000;
        pp_ff[c]       <= 1'b0;
      end
      pend_ff <= {NCH{1'b0}};
    end else if (ce_i) begin
      // latch triggers of enabled channels; disabled ones drop them
      for (c = 0; c < NCH; c = c + 1) begin
        if (!ctl_ff[c][`CTL_EN]) begin
          pend_ff[c]     <= 1'b0;
          force_ff[c]    <= 1'b0;
          idx_ff[c]      <= 14'h0000;
          pp_ff[c]       <= 1'b0;
          ram_addr_ff[c] <= start_addr(prim_hi_ff[c], prim_lo_ff[c]);
        end else if (trig[c] | force_ff[c]) begin
          pend_ff[c] <= 1'b1;
        end
      end
      // the granted channel's request is consumed at start
      if ((state_ff == S_IDLE) & gnt_any) begin
        pend_ff[gnt] <= 1'b0;
      end
      // per-transfer bookkeeping of the current channel
      if (xfer_end) begin
        if (cur_forced_ff) begin
          force_ff[cur_ff] <= 1'b0;
          pend_ff[cur_ff]  <= 1'b0;
        end
        if (cur_am == `AM_INC) begin
          ram_addr_ff[cur_ff] <= ram_addr_ff[cur_ff] + step;
        end
        if (last_xfer) begin
          idx_ff[cur_ff] <= 14'h0000;
          if (pp_mode) begin
            pp_ff[cur_ff] <= ~pp_ff[cur_ff];
            ram_addr_ff[cur_ff] <= pp_ff[cur_ff] ?
              start_addr(prim_hi_ff[cur_ff], prim_lo_ff[cur_ff]) :
              start_addr(sec_hi_ff[cur_ff], sec_lo_ff[cur_ff]);
          end else begin
            ram_addr_ff[cur_ff] <=
              start_addr(prim_hi_ff[cur_ff], prim_lo_ff[cur_ff]);
          end
          // one-shot ends after one block, or after buffer b in ping-pong
          if (one_shot & (~pp_mode | pp_ff[cur_ff])) begin
            ctl_ff[cur_ff][`CTL_EN] <= 1'b0;
            pend_ff[cur_ff]         <= 1'b0;
          end
        end else begin
          idx_ff[cur_ff] <= idx_p1[13:0];
        end
      end
      // software writes, lanes 0 and 1 only
      if (wr_go) begin
        if (reg_idx == `REG_CTL) begin
          ctl_ff[reg_ch] <= merge(ctl_ff[reg_ch], avs_writedata_i[15:0],
                                  wmask & `CTL_MASK);
        end else if (reg_idx == `REG_REQ) begin
          if (avs_byteenable_i[0]) begin
            src_sel_ff[reg_ch] <= avs_writedata_i[7:0];
          end
          // a one sets force on an enabled channel and beats a same-cycle clear; a zero leaves it
          if (avs_byteenable_i[1] & avs_writedata_i[`REQ_FORCE] &
              ctl_ff[reg_ch][`CTL_EN]) begin
            force_ff[reg_ch] <= 1'b1;
          end
        end else if (reg_idx == `REG_PRIM_HI) begin
          if (avs_byteenable_i[0]) begin
            prim_hi_ff[reg_ch] <= avs_writedata_i[7:0];
          end
        end else if (reg_idx == `REG_PRIM_LO) begin
          prim_lo_ff[reg_ch] <= merge(prim_lo_ff[reg_ch],
                                      avs_writedata_i[15:0], wmask);
        end else if (reg_idx == `REG_SEC_HI) begin
          if (avs_byteenable_i[0]) begin
            sec_hi_ff[reg_ch] <= avs_writedata_i[7:0];
          end
        end else if (reg_idx == `REG_SEC_LO) begin
          sec_lo_ff[reg_ch] <= merge(sec_lo_ff[reg_ch],
                                     avs_writedata_i[15:0], wmask);
        end else if (reg_idx == `REG_PERIPH) begin
          // no guard while enabled: software is trusted to stay off
          periph_ff[reg_ch] <= merge(periph_ff[reg_ch],
                                     avs_writedata_i[15:0], wmask);
        end else begin
          xcount_ff[reg_ch] <= xcnt_mrg[13:0];
        end
      end
    end
  end

  // transfer engine: read source, write destination, optional null write
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff      <= S_IDLE;
      cur_ff        <= 2'h0;
      cur_forced_ff <= 1'b0;
      data_ff       <= 16'h0000;
      bus_req_o     <= 1'b0;
      bus_we_o      <= 1'b0;
      bus_ram_o     <= 1'b0;
      bus_byte_o    <= 1'b0;
      bus_addr_o    <= 24'h000000;
      bus_wdata_o   <= 16'h0000;
      blk_int_o     <= 4'h0;
    end else if (ce_i) begin
      blk_int_o <= 4'h0;
      case (state_ff)
        S_IDLE: begin
          if (gnt_any) begin
            cur_ff        <= gnt;
            cur_forced_ff <= force_ff[gnt];
            state_ff      <= S_RD;
          end
        end
        S_RD: begin
          // issue address once cur_ff has settled
          if (!bus_req_o) begin
            bus_req_o  <= 1'b1;
            bus_we_o   <= 1'b0;
            bus_byte_o <= cur_byte;
            bus_ram_o  <= cur_dir;
            bus_addr_o <= cur_dir ? cur_ram : cur_per;
          end else if (bus_ack_i) begin
            data_ff    <= cur_byte ? {8'h00, bus_rdata_i[7:0]} :
                          bus_rdata_i;
            bus_req_o  <= 1'b0;
            state_ff   <= S_WR;
          end
        end
        S_WR: begin
          if (!bus_req_o) begin
            bus_req_o   <= 1'b1;
            bus_we_o    <= 1'b1;
            bus_ram_o   <= ~cur_dir;
            bus_addr_o  <= cur_dir ? cur_per : cur_ram;
            bus_wdata_o <= data_ff;
          end else if (bus_ack_i) begin
            bus_req_o <= 1'b0;
            bus_we_o  <= 1'b0;
            if (cur_ctl[`CTL_NULL_WRITE_MODE] & ~cur_dir) begin
              state_ff <= S_NUL;
            end else begin
              state_ff <= S_IDLE;
            end
          end
        end
        default: begin
          // null data to the peripheral after the ram write
          if (!bus_req_o) begin
            bus_req_o   <= 1'b1;
            bus_we_o    <= 1'b1;
            bus_ram_o   <= 1'b0;
            bus_addr_o  <= cur_per;
            bus_wdata_o <= 16'h0000;
          end else if (bus_ack_i) begin
            bus_req_o <= 1'b0;
            bus_we_o  <= 1'b0;
            state_ff  <= S_IDLE;
          end
        end
      endcase
      // block event: at half or at the end, as chosen
      if (xfer_end) begin
        if (cur_ctl[`CTL_HALF] ? half_hit : last_xfer) begin
          blk_int_o[cur_ff] <= 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ==== testbench/dma_chan_top_sva.sv ====
// assertion checker on the ports of the dma channel block
`timescale 1ns/1ps
`default_nettype none
module dma_chan_top_sva (
  // clock, reset, enable
  input wire logic        mclk_i,
  input wire logic        rst_n_i,
  input wire logic        ce_i,
  // register bus
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  // transfer bus and interrupts
  input wire logic        bus_req_o,
  input wire logic        bus_we_o,
  input wire logic [23:0] bus_addr_o,
  input wire logic [15:0] bus_wdata_o,
  input wire logic        bus_ack_i,
  input wire logic [3:0]  blk_int_o
);
  // one clock domain, so clocking and disable are set once
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  a_write_no_wait: assert property (avs_write_i |-> !avs_waitrequest_o)
    else $error("write was stalled");
  a_read_one_wait: assert property ($rose(avs_read_i) |-> avs_waitrequest_o
    ##1 (!avs_waitrequest_o || !ce_i))
    else $error("read wait state count wrong");
  a_ce_freeze: assert property (!ce_i && avs_read_i && avs_waitrequest_o
    |=> avs_waitrequest_o)
    else $error("read answered while clock enable low");
  a_upper_zero: assert property (avs_readdata_o[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_rdata_stands: assert property (!avs_read_i |=> $stable(avs_readdata_o))
    else $error("read data changed without a read");
  a_bus_held: assert property (bus_req_o && !bus_ack_i |=> bus_req_o &&
    $stable(bus_addr_o) && $stable(bus_we_o) && $stable(bus_wdata_o))
    else $error("bus request changed before ack");
  a_req_drops: assert property (bus_req_o && bus_ack_i && ce_i |=> !bus_req_o)
    else $error("bus request kept after ack");
  a_int_pulse: assert property ((blk_int_o != 4'h0) |=>
    ((blk_int_o & $past(blk_int_o)) == 4'h0))
    else $error("block interrupt longer than one cycle");
  a_int_cause: assert property ((blk_int_o != 4'h0) |->
    $past(bus_req_o) && $past(bus_ack_i) && $past(bus_we_o))
    else $error("block interrupt without completed write");
endmodule

bind dma_chan_top dma_chan_top_sva u_dma_chan_top_sva (.*);
`default_nettype wire

// ==== testbench/dma_bus_model.sv ====
// ram and peripheral data registers answering the transfer bus
`timescale 1ns/1ps
`default_nettype none
module dma_bus_model #(
  parameter logic [15:0] PERIPH_VAL = 16'h5a3c
) (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // access from the channels
  input  wire logic        bus_req_i,
  input  wire logic        bus_we_i,
  input  wire logic        bus_ram_i,
  input  wire logic        bus_byte_i,
  input  wire logic [23:0] bus_addr_i,
  input  wire logic [15:0] bus_wdata_i,
  input  wire logic [1:0]  wait_i,
  // answer
  output var  logic [15:0] bus_rdata_o,
  output var  logic        bus_ack_o
);
  logic [15:0] mem [0:255];
  logic [1:0]  cnt;
  logic [23:0] wr_addr;
  logic [23:0] ram_waddr;
  logic [15:0] wr_data;
  logic        wr_ram;
  logic        wr_byte;
  int          n_wr;

  // each word holds its own index so reads are easy to predict
  initial begin
    for (int k = 0; k < 256; k++) begin
      mem[k] = {k[7:0], ~k[7:0]};
    end
  end

  // ack after wait_i cycles; idle data toggles
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_ack_o <= 1'b0;
      bus_rdata_o <= 16'h0000;
      cnt <= 2'h0;
      n_wr <= 0;
    end else begin
      bus_ack_o <= 1'b0;
      bus_rdata_o <= ~bus_rdata_o;
      if (bus_req_i && !bus_ack_o) begin
        if (cnt != wait_i) begin
          cnt <= cnt + 2'h1;
        end else begin
          cnt <= 2'h0;
          bus_ack_o <= 1'b1;
          if (!bus_we_i) begin
            bus_rdata_o <= bus_ram_i ?
              mem[bus_addr_i[8:1]] >> {bus_addr_i[0], 3'h0} : PERIPH_VAL;
          end else begin
            n_wr <= n_wr + 1;
            wr_addr <= bus_addr_i;
            wr_data <= bus_wdata_i;
            wr_ram <= bus_ram_i;
            wr_byte <= bus_byte_i;
            if (bus_ram_i) begin
              ram_waddr <= bus_addr_i;
              mem[bus_addr_i[8:1]] <= bus_wdata_i;
            end
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench/test_dma_chan_top.sv ====
// register and transfer tests of the dma channel block
`timescale 1ns/1ps
`default_nettype none
`include "dma_chan_regs.vh"
module test_dma_chan_top;
  logic         mclk_i, rst_n_i, ce_i, avs_read_i, avs_write_i;
  logic [6:0]   avs_address_i;
  logic [3:0]   avs_byteenable_i, blk_int_o;
  logic [31:0]  avs_writedata_i, avs_readdata_o, q;
  logic         avs_waitrequest_o, bus_req_o, bus_we_o, bus_ram_o;
  logic         bus_byte_o, bus_ack_i;
  logic [255:0] req_i;
  logic [15:0]  periph_offset_i, bus_wdata_o, bus_rdata_i;
  logic [23:0]  bus_addr_o;
  logic [1:0]   wait_cyc;
  logic [15:0]  wv [8] = '{16'h7fff, 16'hffff, 16'hffff, 16'hffff,
                           16'hffff, 16'ha5a5, 16'hffff, 16'hffff};
  logic [15:0]  ev [8] = '{16'h7833, 16'h00ff, 16'h00ff, 16'hffff,
                           16'h00ff, 16'ha5a5, 16'hffff, 16'h3fff};
  logic [7:0]   codes [22] = '{8'h00, 8'h01, 8'h05, 8'h25, 8'h26, 8'h02,
    8'h06, 8'h19, 8'h1a, 8'h07, 8'h08, 8'h1b, 8'h1c, 8'h0a, 8'h21, 8'h0b,
    8'h0c, 8'h1e, 8'h1f, 8'h0d, 8'h22, 8'h46};
  int           err_count, n_checks, external_interrupt_zero, n;

  dma_chan_top u_dma_chan_top (.*);
  dma_bus_model u_dma_bus_model (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .bus_req_i(bus_req_o), .bus_we_i(bus_we_o), .bus_ram_i(bus_ram_o),
    .bus_byte_i(bus_byte_o), .bus_addr_i(bus_addr_o),
    .bus_wdata_i(bus_wdata_o), .wait_i(wait_cyc),
    .bus_rdata_o(bus_rdata_i), .bus_ack_o(bus_ack_i));

  // 40 mhz clock
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  // block interrupts of channel 0
  always @(posedge mclk_i) if (blk_int_o[0] === 1'b1) external_interrupt_zero++;

  task automatic check(input string what, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // avalon write: held until waitrequest is sampled low
  task automatic wr(input logic [1:0] ch, input logic [2:0] ix,
                    input logic [15:0] d);
    @(posedge mclk_i);
    avs_address_i <= {ch, ix, 2'h0};
    avs_writedata_i <= {16'h0000, d};
    avs_write_i <= 1'b1;
    do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
    avs_write_i <= 1'b0;
  endtask

  // avalon read compared against an expected value
  task automatic rchk(input logic [1:0] ch, input logic [2:0] ix,
                      input logic [15:0] e);
    logic w;
    @(posedge mclk_i);
    avs_address_i <= {ch, ix, 2'h0};
    avs_read_i <= 1'b1;
    // waitrequest is combinational, so it is read settled before the edge
    do begin
      @(negedge mclk_i);
      w = avs_waitrequest_o;
      @(posedge mclk_i);
    end while (w !== 1'b0);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    check("register read", q, {16'h0000, e});
  endtask

  // one request pulse, then wait for the model's write count
  task automatic trig(input logic [7:0] c, input int nw);
    @(posedge mclk_i);
    req_i[c] <= 1'b1;
    @(posedge mclk_i);
    req_i[c] <= 1'b0;
    wait (u_dma_bus_model.n_wr == nw);
    repeat (6) @(posedge mclk_i);
  endtask

  task automatic results;
    if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // hang guard
  initial begin
    #(25 * 60000);
    err_count++;
    results;
  end

  initial begin
    {ce_i, avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
    {req_i, periph_offset_i, wait_cyc} = '0;
    avs_byteenable_i = 4'h3;
    rst_n_i = 1'b0;
    repeat (12) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    // read stalled by ce low, then reset values and masks
    fork
      rchk(2'd0, `REG_CTL, 16'h0000);
      begin repeat (3) @(posedge mclk_i); ce_i <= 1'b1; end
    join
    for (int i = 0; i < 8; i++) begin
      rchk(2'd3, i, 16'h0000);
      wr(2'd3, i, wv[i]);
      rchk(2'd3, i, ev[i]);
    end
    // word, peripheral to ram, post-increment, continuous, two per block
    wr(0, `REG_PRIM_LO, 16'h0010);
    wr(0, `REG_PERIPH, 16'h0040);
    wr(0, `REG_XCOUNT, 16'h0001);
    wr(0, `REG_REQ, `SRC_SER_RX_1);
    wr(0, `REG_CTL, 16'h8000);
    trig(`SRC_SER_RX_1, 1);
    check("ram addr", u_dma_bus_model.wr_addr, 24'h000010);
    check("to ram", u_dma_bus_model.wr_ram, 1'b1);
    check("word data", u_dma_bus_model.wr_data, 16'h5a3c);
    check("no int yet", external_interrupt_zero, 0);
    trig(`SRC_SER_RX_1, 2);
    check("next addr", u_dma_bus_model.wr_addr, 24'h000012);
    check("full int", external_interrupt_zero, 1);
    trig(`SRC_SER_RX_1, 3);
    check("reload", u_dma_bus_model.wr_addr, 24'h000010);
    // other source, then disabled channel: nothing moves
    req_i[`SRC_SER_TX_1] <= 1'b1;
    wr(0, `REG_CTL, 16'h0000);
    req_i[`SRC_SER_TX_1] <= 1'b0;
    trig(`SRC_SER_RX_1, 3);
    check("no transfer", u_dma_bus_model.n_wr, 3);
    // every source code, no increment, varying far side delay
    wr(1, `REG_PRIM_LO, 16'h0050);
    wr(1, `REG_CTL, 16'h8010);
    foreach (codes[i]) begin
      n = u_dma_bus_model.n_wr + 1;
      wr(1, `REG_REQ, {8'h00, codes[i]});
      wait_cyc <= codes[i][1:0];
      trig(codes[i], n);
      check("source", u_dma_bus_model.wr_addr, 24'h000050);
    end
    wr(1, `REG_CTL, 16'h0000);
    // forced byte, ram to peripheral, one-shot; a zero write keeps force
    n = u_dma_bus_model.n_wr + 1;
    wr(2, `REG_PRIM_LO, 16'h0021);
    wr(2, `REG_PERIPH, 16'h0044);
    wr(2, `REG_CTL, 16'he011);
    wr(2, `REG_REQ, 16'h8003);
    wr(2, `REG_REQ, 16'h0003);
    trig(8'h03, n);
    repeat (20) @(posedge mclk_i);
    check("one forced", u_dma_bus_model.n_wr, n);
    check("periph addr", u_dma_bus_model.wr_addr, 24'h000044);
    check("byte", {u_dma_bus_model.wr_byte, u_dma_bus_model.wr_data[7:0]},
          9'h110);
    rchk(2, `REG_REQ, 16'h0003);
    rchk(2, `REG_CTL, 16'h6011);
    // continuous ping-pong with null writes, software keeps direction clear
    wr(2, `REG_SEC_LO, 16'h0040);
    wr(2, `REG_PRIM_LO, 16'h0030);
    wr(2, `REG_REQ, `SRC_ANALOG);
    wr(2, `REG_CTL, 16'h8802);
    trig(`SRC_ANALOG, n + 2);
    check("buf a", u_dma_bus_model.ram_waddr, 24'h000030);
    check("null", {u_dma_bus_model.wr_ram, u_dma_bus_model.wr_data},
          17'h00000);
    trig(`SRC_ANALOG, n + 4);
    check("buf b", u_dma_bus_model.ram_waddr, 24'h000040);
    // half-block interrupt on a one-shot block of four
    wr(0, `REG_XCOUNT, 16'h0003);
    wr(0, `REG_CTL, 16'h9001);
    n = u_dma_bus_model.n_wr;
    for (int k = 1; k <= 4; k++) begin
      trig(`SRC_SER_RX_1, n + k);
      if (k == 2) check("half int", external_interrupt_zero, 2);
    end
    check("no full int", external_interrupt_zero, 2);
    rchk(0, `REG_CTL, 16'h1001);
    results;
  end
endmodule
`default_nettype wire
